// ---- src/gfb_consts.vh ----
`ifndef GFB_CONSTS_VH
`define GFB_CONSTS_VH
// Notes on behaviour
// - decode accumulate with mask from vector seven
// - xor masked source bytes into destination low byte
// - operations never touch status flag bits
// - parallel accumulate also loads third register
// - parallel compute and load finish together
// - decode lane add with lane mask immediate
// - masked lanes xor, others copy first source
// - field setup loads polynomial and order
// - lane mac: dest times first, xor second
// - products use current polynomial and order
// - lane multiply of two source registers
// - parallel multiply also loads vector zero
// - mac with replicate fills vector zero
// - replicate selected memory byte into lanes
// - every operation completes in one cycle
// - decode accumulate with immediate mask

// register byte offsets
`define GFB_VR_BASE        8'h00
`define GFB_VR_SPAN        8'h20
`define GFB_STATUS_OFS     8'h20
`define GFB_MEMDATA_OFS    8'h24
`define GFB_OPCODE_OFS     8'h28

// status layout
`define GFB_POLY_LSB       0
`define GFB_POLY_MSB       7
`define GFB_ORDER_LSB      8
`define GFB_ORDER_MSB      10
`define GFB_FLAGS_LSB      16
`define GFB_STATUS_WMASK   32'hffff07ff

// reset values
`define GFB_STATUS_RST     32'h00000000
`define GFB_VR_RST         32'h00000000
`define GFB_WORD_RST       32'h00000000

// first-word opcodes
`define GFB_LSW_LANE       16'he680
`define GFB_LSW_ACC        16'he681
`define GFB_LSW_SETUP      16'he2c5
`define GFB_LSW_REPL       16'he2b1
`define GFB_LSW_PACC       15'h715b
`define GFB_LSW_PMPY       15'h715a
`define GFB_LSW_PMAC       13'h1c57

// second-word prefixes
`define GFB_MSW_ACC_VR     10'h010
`define GFB_MSW_ACC_IMM    6'h00
`define GFB_MSW_ADD        3'h0
`define GFB_MSW_MAC        7'h11
`define GFB_MSW_MPY        7'h10
`endif

// ---- src/gfb_unit.v ----
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "gfb_consts.vh"

module gfb_unit (
   // clock and reset
   input  wire        CORE_CLK,
   input  wire        SRST,
   // apb slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR
);

   // operation classes
   localparam [2:0] OP_NONE  = 3'd0;
   localparam [2:0] OP_ACC   = 3'd1;
   localparam [2:0] OP_ADD   = 3'd2;
   localparam [2:0] OP_MAC   = 3'd3;
   localparam [2:0] OP_MPY   = 3'd4;
   localparam [2:0] OP_REPL  = 3'd5;
   localparam [2:0] OP_SETUP = 3'd6;

   // architectural state
   reg  [31:0] vr [0:7];
   reg  [31:0] status;
   reg  [31:0] memdata;
   reg  [31:0] opword;

   // decoded instruction
   reg  [2:0]  op;
   reg  [2:0]  ia;
   reg  [2:0]  ib;
   reg  [2:0]  ic;
   reg  [3:0]  imm;
   reg         use_vr7;
   reg         ld_en;
   reg         ld_repl;
   reg  [2:0]  ld_idx;
   reg  [1:0]  sel;

   // operands and lane results
   wire [15:0] lsw;
   wire [15:0] msw;
   wire [31:0] va;
   wire [31:0] vb;
   wire [31:0] vc;
   wire [3:0]  mask;
   wire [7:0]  poly;
   wire [2:0]  order;
   wire [31:0] mpy_res;
   wire [31:0] mac_res;
   wire [31:0] add_res;
   wire [31:0] acc_term;
   wire [7:0]  acc_byte;
   reg  [7:0]  rep_byte;
   wire [31:0] rep_word;
   reg  [31:0] res;

   // bus decode
   wire        acc_phase;
   wire        done;
   wire        vr_hit;
   wire [2:0]  vr_idx;
   reg  [31:0] rd_mux;
   reg         err;

   // field product: shift-and-add, reduced whenever the symbol top bit carries out
   function [7:0] gf_mul;
      input [7:0] a;
      input [7:0] b;
      input [7:0] p;
      input [2:0] ord;
      reg   [7:0] msk;
      reg   [7:0] top;
      reg   [7:0] acc;
      reg         carry;
      integer     i;
      begin
         // an order below seven shrinks the symbol; the loop length stays fixed at eight
         msk = 8'hff >> (~ord);
         top = 8'h01 << ord;
         acc = 8'h00;
         for (i = 7; i >= 0; i = i - 1) begin
            carry = |(acc & top);
            acc = ((acc << 1) & msk) ^ (carry ? (p & msk) : 8'h00);
            // multiplier bits above the symbol width are ignored, as for the multiplicand
            if (b[i] & msk[i]) begin
               acc = acc ^ (a & msk);
            end
         end
         gf_mul = acc;
      end
   endfunction

   assign lsw   = PWDATA[15:0];
   assign msw   = PWDATA[31:16];
   assign poly  = status[`GFB_POLY_MSB:`GFB_POLY_LSB];
   assign order = status[`GFB_ORDER_MSB:`GFB_ORDER_LSB];

   // opcode decode straight from the write data held by the master
   // a word that matches no pattern leaves op at none, which the bus refuses
   always @* begin
      op      = OP_NONE;
      ia      = 3'd0;
      ib      = 3'd0;
      ic      = 3'd0;
      imm     = 4'h0;
      use_vr7 = 1'b0;
      ld_en   = 1'b0;
      ld_repl = 1'b0;
      ld_idx  = 3'd0;
      sel     = 2'd0;
      if (lsw == `GFB_LSW_ACC) begin
         if (msw[15:6] == `GFB_MSW_ACC_VR) begin
            op      = OP_ACC;
            ia      = msw[5:3];
            ib      = msw[2:0];
            use_vr7 = 1'b1;
         end else if (msw[15:10] == `GFB_MSW_ACC_IMM) begin
            op  = OP_ACC;
            ia  = msw[9:7];
            ib  = msw[6:4];
            imm = msw[3:0];
         end
      end else if (lsw == `GFB_LSW_LANE) begin
         if (msw[15:13] == `GFB_MSW_ADD) begin
            op  = OP_ADD;
            ia  = msw[12:10];
            ib  = msw[9:7];
            ic  = msw[6:4];
            imm = msw[3:0];
         end else if (msw[15:9] == `GFB_MSW_MAC) begin
            op = OP_MAC;
            ia = msw[8:6];
            ib = msw[5:3];
            ic = msw[2:0];
         end else if (msw[15:9] == `GFB_MSW_MPY) begin
            op = OP_MPY;
            ia = msw[8:6];
            ib = msw[5:3];
            ic = msw[2:0];
         end
      end else if (lsw[15:1] == `GFB_LSW_PACC) begin
         op      = OP_ACC;
         ia      = {lsw[0], msw[15:14]};
         ib      = msw[13:11];
         use_vr7 = 1'b1;
         ld_en   = 1'b1;
         ld_idx  = msw[10:8];
      end else if (lsw[15:1] == `GFB_LSW_PMPY) begin
         op     = OP_MPY;
         ia     = {lsw[0], msw[15:14]};
         ib     = msw[13:11];
         ic     = msw[10:8];
         ld_en  = 1'b1;
      end else if (lsw[15:3] == `GFB_LSW_PMAC) begin
         op      = OP_MAC;
         ia      = {lsw[0], msw[15:14]};
         ib      = msw[13:11];
         ic      = msw[10:8];
         ld_en   = 1'b1;
         ld_repl = 1'b1;
         sel     = lsw[2:1];
      end else if (lsw == `GFB_LSW_REPL) begin
         op  = OP_REPL;
         ia  = msw[12:10];
         sel = msw[9:8];
      end else if (lsw == `GFB_LSW_SETUP) begin
         op = OP_SETUP;
      end
   end

   // register fields are 3 bits wide, so all eight vector registers are reachable
   assign va   = vr[ia];
   assign vb   = vr[ib];
   assign vc   = vr[ic];
   // the mask register form reads only the low nibble of vector seven
   assign mask = use_vr7 ? vr[7][3:0] : imm;

   // four byte lanes, all fed from the values held before the instruction
   // all eight multipliers, two per lane, are unrolled, trading area for the single-cycle result
   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_lane
         wire [7:0] ak = va[8*k+7:8*k];
         wire [7:0] bk = vb[8*k+7:8*k];
         wire [7:0] ck = vc[8*k+7:8*k];
         assign mpy_res[8*k+7:8*k]  = gf_mul(bk, ck, poly, order);
         assign mac_res[8*k+7:8*k]  = gf_mul(ak, bk, poly, order) ^ ck;
         assign add_res[8*k+7:8*k]  = imm[k] ? (bk ^ ck) : bk;
         assign acc_term[8*k+7:8*k] = mask[k] ? bk : 8'h00;
      end
   endgenerate

   // xor is order free, so the sequential mask walk collapses to one term
   assign acc_byte = va[7:0] ^ acc_term[7:0] ^ acc_term[15:8]
                     ^ acc_term[23:16] ^ acc_term[31:24];

   // byte selector for replicate loads
   // the selector comes from the second word, or from the first word in the parallel form
   always @* begin
      case (sel)
         2'd0:    rep_byte = memdata[7:0];
         2'd1:    rep_byte = memdata[15:8];
         2'd2:    rep_byte = memdata[23:16];
         default: rep_byte = memdata[31:24];
      endcase
   end
   assign rep_word = {4{rep_byte}};

   // destination value
   always @* begin
      case (op)
         OP_ACC:  res = {va[31:8], acc_byte};
         OP_ADD:  res = add_res;
         OP_MAC:  res = mac_res;
         OP_MPY:  res = mpy_res;
         OP_REPL: res = rep_word;
         default: res = va;
      endcase
   end

   // apb decode; the answer comes one cycle into the access phase
   assign acc_phase = PSEL & PENABLE;
   assign done      = acc_phase & PREADY;
   assign vr_hit    = (PADDR < (`GFB_VR_BASE + `GFB_VR_SPAN)) && (PADDR[1:0] == 2'b00);
   assign vr_idx    = PADDR[4:2];

   // read data and error, sampled before pready rises
   always @* begin
      rd_mux = 32'h00000000;
      err    = 1'b0;
      if (vr_hit) begin
         rd_mux = vr[vr_idx];
      end else if (PADDR == `GFB_STATUS_OFS) begin
         rd_mux = status;
      end else if (PADDR == `GFB_MEMDATA_OFS) begin
         rd_mux = memdata;
      end else if (PADDR == `GFB_OPCODE_OFS) begin
         rd_mux = opword;
         err    = PWRITE & (op == OP_NONE); // unknown opcode is refused
      end else begin
         err = 1'b1;
      end
   end

   // bus handshake outputs
   // one wait state always: ready rises the cycle after the first access edge
   always @(posedge CORE_CLK) begin
      if (SRST) begin
         PREADY  <= 1'b0;
         PRDATA  <= `GFB_WORD_RST;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= acc_phase & ~PREADY;
         if (acc_phase & ~PREADY) begin
            PRDATA  <= PWRITE ? `GFB_WORD_RST : rd_mux;
            PSLVERR <= err;
         end else begin
            PSLVERR <= 1'b0;
         end
      end
   end

   // state update: software writes and single-cycle execution
   // a refused write never lands, since its error flag is already registered
   integer r;
   always @(posedge CORE_CLK) begin
      if (SRST) begin
         for (r = 0; r < 8; r = r + 1) begin
            vr[r] <= `GFB_VR_RST;
         end
         status  <= `GFB_STATUS_RST;
         memdata <= `GFB_WORD_RST;
         opword  <= `GFB_WORD_RST;
      end else if (done & PWRITE & ~PSLVERR) begin
         if (vr_hit) begin
            vr[vr_idx] <= PWDATA;
         end else if (PADDR == `GFB_STATUS_OFS) begin
            status <= PWDATA & `GFB_STATUS_WMASK;
         end else if (PADDR == `GFB_MEMDATA_OFS) begin
            memdata <= PWDATA;
         end else if (PADDR == `GFB_OPCODE_OFS) begin
            opword <= PWDATA;
            // only the polynomial and order move; flag bits stay as they are
            if (op == OP_SETUP) begin
               status[`GFB_ORDER_MSB:`GFB_POLY_LSB] <= memdata[10:0];
            end else begin
               vr[ia] <= res;
            end
            // load lands on the same edge; it wins if it names the destination
            if (ld_en) begin
               vr[ld_idx] <= ld_repl ? rep_word : memdata;
            end
         end
      end
   end

endmodule // gfb_unit

// ---- test/gfb_props.sv ----
`timescale 1ns/1ps
`include "gfb_consts.vh"
module gfb_props (
   // clock and reset
   input wire logic        CORE_CLK,
   input wire logic        SRST,
   // apb
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR
);
   logic [15:0] flags;
   wire         rd_st = PREADY && !PWRITE && PADDR == `GFB_STATUS_OFS;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   // flag bits may only move through a status write
   always @(posedge CORE_CLK)
      if (SRST)
         flags <= 16'h0;
      else if (PREADY && PWRITE && !PSLVERR && PADDR == `GFB_STATUS_OFS)
         flags <= PWDATA[31:16];

   // handshake timing and refusals
   a_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("ready late");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held");
   a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE) && PSEL)
      else $error("ready without access");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   a_err_addr: assert property (PREADY && (PADDR > `GFB_OPCODE_OFS || PADDR[1:0] != 2'h0)
      |-> PSLVERR) else $error("bad address taken");
   a_vr_open: assert property (
      PREADY && PADDR < `GFB_STATUS_OFS && PADDR[1:0] == 2'h0 |-> !PSLVERR)
      else $error("vector access refused");
   a_wr_zero: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
      else $error("read data on write");
   a_flags_kept: assert property (rd_st |-> PRDATA[31:16] == flags)
      else $error("flag bits moved");
   a_stat_gap: assert property (rd_st |-> PRDATA[15:11] == 5'h0)
      else $error("status gap not zero");

   // main scenarios reached
   c_refused: cover property (PREADY && PSLVERR);
   c_exec: cover property (PREADY && PWRITE && PADDR == `GFB_OPCODE_OFS);
   c_status: cover property (rd_st);
endmodule // gfb_props

bind gfb_unit gfb_props u_props (.CORE_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PWDATA, .PRDATA, .PREADY, .PSLVERR);

// ---- test/gfb_host.sv ----
`timescale 1ns/1ps
module gfb_host (
   // clock
   input wire logic        clk,
   // apb request
   output logic            psel,
   output logic            penable,
   output logic            pwrite,
   output logic [7:0]      paddr,
   output logic [31:0]     pwdata,
   // apb answer
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   // bus idle until a transfer is asked for
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end

   // one transfer, held until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      // released lines show the inverse, except pwrite, which keeps its stale value
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // gfb_host

// ---- test/galois_field_byte_unit_bench.sv ----
`timescale 1ns/1ps
`include "gfb_consts.vh"
module galois_field_byte_unit_bench;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr, x, y, z;
   logic [31:0] pwdata, prdata, rd, mem, lw, st, vr[8], t[8];
   logic [3:0]  im;
   logic [2:0]  a, b, c;
   logic [1:0]  s;
   int          fail_count = 0, samples_checked = 0, k;

   // core clock, 5 ns period
   initial forever #2.5 clk = ~clk;

   gfb_host HOST (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   gfb_unit DUT (.CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

   // reference field product, msb first, width set by the order field
   function automatic logic [7:0] gm(input logic [7:0] u, v);
      int w, m, p;
      w = st[10:8] + 1;
      m = (1 << w) - 1;
      p = 0;
      for (int i = w - 1; i >= 0; i--) begin
         p = p << 1;
         if (p[w]) p = p ^ (m + 1) ^ (st[7:0] & m);
         if (v[i]) p = p ^ (u & m);
      end
      return p[7:0];
   endfunction

   task automatic chk(input string n, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
      end
   endtask

   // one access; the refusal flag is always compared
   task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic e);
      HOST.xfer(w, ad, d, rd, er);
      chk("pslverr", {31'h0, er}, {31'h0, e});
   endtask

   task automatic op(input logic [15:0] ls, ms);
      lw = {ms, ls};
      acc(1'b1, `GFB_OPCODE_OFS, lw, 1'b0);
   endtask

   // read back the vector, status and opcode registers against the model
   task automatic cmp_all;
      for (int i = 0; i < 8; i++) begin
         acc(1'b0, 8'(4 * i), 32'h0, 1'b0);
         chk("vector", rd, vr[i]);
      end
      acc(1'b0, `GFB_STATUS_OFS, 32'h0, 1'b0);
      chk("status", rd, st);
      acc(1'b0, `GFB_OPCODE_OFS, 32'h0, 1'b0);
      chk("opcode", rd, lw);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // reset values, random instruction stream, refused accesses
   initial begin
      k = $urandom(32'hc47d);
      {lw, st, mem} = '0;
      foreach (vr[i]) vr[i] = 32'h0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      cmp_all;
      $display("test reset done");
      for (int n = 0; n < 80; n++) begin
         if (n % 16 == 0) begin
            for (int i = 0; i < 8; i++) begin
               vr[i] = $urandom;
               acc(1'b1, 8'(4 * i), vr[i], 1'b0);
            end
            st = $urandom & `GFB_STATUS_WMASK;
            acc(1'b1, `GFB_STATUS_OFS, st | 32'h0000f800, 1'b0);
         end
         mem = $urandom;
         acc(1'b1, `GFB_MEMDATA_OFS, mem, 1'b0);
         {a, b, c, im, s} = 15'($urandom);
         k = $urandom % 10;
         t = vr;
         case (k)
            0: op(16'he681, {10'h010, a, b});
            1: op(16'he681, {6'h0, a, b, im});
            2: op(16'he680, {3'h0, a, b, c, im});
            3: op(16'he680, {7'h11, a, b, c});
            4: op(16'he680, {7'h10, a, b, c});
            5: op(16'he2c5, 16'h0);
            6: op(16'he2b1, {3'h0, a, s, 8'h0});
            7: op({15'h715b, a[2]}, {a[1:0], b, c, 8'h0});
            8: op({15'h715a, a[2]}, {a[1:0], b, c, 8'h0});
            default: op({13'h1c57, s, a[2]}, {a[1:0], b, c, 8'h0});
         endcase
         // lanes read pre-instruction values; a parallel load wins
         for (int j = 0; j < 4; j++) begin
            {x, y, z} = {t[b][8*j+:8], t[c][8*j+:8], t[a][8*j+:8]};
            if ((k == 0 || k == 7) && t[7][j] || k == 1 && im[j]) vr[a][7:0] ^= x;
            if (k == 2) vr[a][8*j+:8] = im[j] ? x ^ y : x;
            if (k == 3 || k == 9) vr[a][8*j+:8] = gm(z, x) ^ y;
            if (k == 4 || k == 8) vr[a][8*j+:8] = gm(x, y);
         end
         if (k == 5) st[10:0] = mem[10:0];
         if (k == 6 || k == 9) vr[k == 6 ? a : 3'h0] = {4{mem[8*s+:8]}};
         if (k == 7) vr[c] = mem;
         if (k == 8) vr[0] = mem;
         cmp_all;
      end
      $display("test random done");
      acc(1'b1, 8'h2c, 32'h1, 1'b1);
      acc(1'b0, 8'h06, 32'h0, 1'b1);
      acc(1'b1, `GFB_OPCODE_OFS, 32'h0000ffff, 1'b1);
      cmp_all;
      $display("test refused done");
      test_done;
   end

   // watchdog far beyond the few thousand cycles the run needs
   initial begin
      #200000;
      fail_count++;
      test_done;
   end
endmodule // galois_field_byte_unit_bench
